// ==== rtl/sosr_router.sv ====
// Purpose: routes drive status signals onto three output terminals
// Assumes: status and mode inputs are asynchronous to ref_clk
// Notes:   outputs lag status inputs by five clock edges
//
// The register offsets and the plain strobed port are this design's own decisions.

module sosr_router (
   input  wire logic                   ref_clk,
   input  wire logic                   rst_b,
   input  wire sosr_pkg::sosr_req_t    req,
   output logic      [15:0]            rdata,
   input  wire sosr_pkg::sosr_status_t status_in,
   input  wire sosr_pkg::sosr_mode_t   mode_in,
   output logic                        output_terminal_one,
   output logic                        output_terminal_two,
   output logic                        output_terminal_three
);
   import sosr_pkg::*;

   logic [15:0]         output_route_select_a;
   logic [15:0]         output_route_select_b;
   logic [15:0]         output_route_select_c;
   logic [15:0]         output_polarity_select;
   sosr_status_t        status_s;
   logic [1:0]          mode_s;
   logic [NUM_SIG-1:0]  sig_eff;
   logic [SEL_W*NUM_SIG-1:0] sel_all;
   logic [NUM_OUT-1:0]  next_out;
   logic [NUM_OUT-1:0]  out_q;

   // ==========================================================
   // input synchronisers: status bits and mode share one filter
   sosr_sync #(
      .W ($bits(sosr_status_t) + 2)
   ) u_sync (
      .ref_clk (ref_clk),
      .rst_b   (rst_b),
      .din     ({status_in, mode_in}),
      .dout    ({status_s, mode_s})
   );

   // ==========================================================
   // register writes; reserved digits stay zero
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         output_route_select_a  <= RST_ROUTE_A;
         output_route_select_b  <= RST_ROUTE_B;
         output_route_select_c  <= RST_ROUTE_C;
         output_polarity_select <= RST_POLARITY;
      end else if (req.wr) begin
         case (req.addr)
            ADDR_ROUTE_A:  output_route_select_a  <= req.wdata & 16'h3333;
            ADDR_ROUTE_B:  output_route_select_b  <= req.wdata & 16'h3333;
            ADDR_ROUTE_C:  output_route_select_c  <= req.wdata & {12'h000, ROUTE_C_MASK};
            ADDR_POLARITY: output_polarity_select <= req.wdata & {12'h000, POL_MASK};
            default: ;
         endcase
      end
   end

   // ==========================================================
   // register reads, one cycle later; unmapped reads zero
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         rdata <= 16'h0000;
      end else if (req.rd) begin
         case (req.addr)
            ADDR_ROUTE_A:  rdata <= output_route_select_a;
            ADDR_ROUTE_B:  rdata <= output_route_select_b;
            ADDR_ROUTE_C:  rdata <= output_route_select_c;
            ADDR_POLARITY: rdata <= output_polarity_select;
            ADDR_STATUS:   rdata <= {11'h000, mode_s, out_q};
            default:       rdata <= 16'h0000;
         endcase
      end else begin
         rdata <= 16'h0000;
      end
   end

   // ==========================================================
   // mode forcing and warning build; torque mode detects neither
   // positioning nor speed coincidence
   always_comb begin
      sig_eff = '0;
      sig_eff[0] = status_s.positioning_complete
                   && (mode_s == SOSR_MODE_POSITION);
      sig_eff[1] = status_s.speed_coincidence
                   && (mode_s != SOSR_MODE_TORQUE);
      sig_eff[2] = status_s.motor_rotating;
      sig_eff[3] = status_s.servo_ready;
      sig_eff[4] = status_s.torque_limit_active;
      sig_eff[5] = status_s.speed_limit_active;
      sig_eff[6] = status_s.holding_brake_release;
      sig_eff[7] = status_s.overload | status_s.regen_overload;
      sig_eff[8] = status_s.approach_window
                   && (mode_s == SOSR_MODE_POSITION);
   end

   // selectors in signal order, two bits from each nibble
   generate
      for (genvar k = 0; k < NUM_SIG; k++) begin : g_sel
         localparam int REG_BITS = k * NIB_W;
         if (k < 4) begin : g_a
            assign sel_all[k*SEL_W +: SEL_W] = output_route_select_a[REG_BITS +: SEL_W];
         end else if (k < 8) begin : g_b
            assign sel_all[k*SEL_W +: SEL_W] = output_route_select_b[REG_BITS-16 +: SEL_W];
         end else begin : g_c
            assign sel_all[k*SEL_W +: SEL_W] = output_route_select_c[REG_BITS-32 +: SEL_W];
         end
      end
   endgenerate

   // ==========================================================
   // or-combine per terminal, then polarity on the combined value
   always_comb begin
      next_out = '0;
      for (int t = 0; t < NUM_OUT; t++) begin
         for (int k = 0; k < NUM_SIG; k++) begin
            if (sel_all[k*SEL_W +: SEL_W] == 2'(t + 1)) begin
               next_out[t] = next_out[t] | sig_eff[k];
            end
         end
         next_out[t] = next_out[t] ^ output_polarity_select[t];
      end
   end

   // registered copy of the terminals, read back through the status register
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         out_q <= '0;
      end else begin
         out_q <= next_out;
      end
   end

   // ==========================================================
   // terminal pins straight from flip-flops
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         output_terminal_one   <= 1'b0;
         output_terminal_two   <= 1'b0;
         output_terminal_three <= 1'b0;
      end else begin
         output_terminal_one   <= next_out[0];
         output_terminal_two   <= next_out[1];
         output_terminal_three <= next_out[2];
      end
   end
endmodule

// ==== rtl/sosr_pkg.sv ====
// Purpose: shared constants and types for the servo output signal router
// Assumes: 16-bit registers on a plain strobe port, one nibble per selector
// Notes:   register indices are word addresses on the port
package sosr_pkg;
   // ==========================================================
   // register map
   localparam logic [3:0]  ADDR_ROUTE_A  = 4'h0;
   localparam logic [3:0]  ADDR_ROUTE_B  = 4'h1;
   localparam logic [3:0]  ADDR_ROUTE_C  = 4'h2;
   localparam logic [3:0]  ADDR_POLARITY = 4'h3;
   localparam logic [3:0]  ADDR_STATUS   = 4'h4;
   // ==========================================================
   // reset values
   localparam logic [15:0] RST_ROUTE_A   = 16'h3211;
   localparam logic [15:0] RST_ROUTE_B   = 16'h0000;
   localparam logic [15:0] RST_ROUTE_C   = 16'h0000;
   localparam logic [15:0] RST_POLARITY  = 16'h0000;
   // ==========================================================
   // field layout
   localparam int          SEL_W         = 2;
   localparam int          NIB_W         = 4;
   localparam int          NUM_SIG       = 9;
   localparam int          NUM_OUT       = 3;
   localparam logic [1:0]  SEL_OFF       = 2'h0;
   localparam logic [3:0]  ROUTE_C_MASK  = 4'h3;
   localparam logic [3:0]  POL_MASK      = 4'h7;
   localparam int          SYNC_STAGES   = 3;

   // ==========================================================
   // control modes
   typedef enum logic [1:0] {
      SOSR_MODE_POSITION = 2'b00,
      SOSR_MODE_SPEED    = 2'b01,
      SOSR_MODE_TORQUE   = 2'b10
   } sosr_mode_t;

   // raw status signals from the drive
   typedef struct packed {
      logic approach_window;
      logic regen_overload;
      logic overload;
      logic holding_brake_release;
      logic speed_limit_active;
      logic torque_limit_active;
      logic servo_ready;
      logic motor_rotating;
      logic speed_coincidence;
      logic positioning_complete;
   } sosr_status_t;

   // register port request
   typedef struct packed {
      logic [3:0]  addr;
      logic [15:0] wdata;
      logic        wr;
      logic        rd;
   } sosr_req_t;
endpackage

// ==== rtl/sosr_sync.sv ====
// Purpose: three-stage synchroniser with agreement filter
// Assumes: input comes from another clock domain
// Notes:   output changes only when stages two and three agree
module sosr_sync #(
   parameter int W = 1
) (
   input  wire logic         ref_clk,
   input  wire logic         rst_b,
   input  wire logic [W-1:0] din,
   output logic      [W-1:0] dout
);
   import sosr_pkg::*;
   logic [W-1:0] s1;
   logic [W-1:0] s2;
   logic [W-1:0] s3;

   // ==========================================================
   // shift chain; s1 read only by s2 to keep metastability contained
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         s1 <= '0;
         s2 <= '0;
         s3 <= '0;
      end else begin
         s1 <= din;
         s2 <= s1;
         s3 <= s2;
      end
   end

   // accept a bit once the last two stages agree
   generate
      for (genvar i = 0; i < W; i++) begin : g_filt
         always_ff @(posedge ref_clk or negedge rst_b) begin
            if (!rst_b) begin
               dout[i] <= 1'b0;
            end else if (s2[i] == s3[i]) begin
               dout[i] <= s3[i];
            end
         end
      end
   endgenerate
endmodule

// ==== verif/sosr_router_sva.sv ====
// Purpose: port assertions for the output router
// Assumes: one clock, async low reset
// Notes:   a quiet counter marks settled inputs
module sosr_router_sva (
   input wire logic                   ref_clk,
   input wire logic                   rst_b,
   input wire sosr_pkg::sosr_req_t    req,
   input wire logic [15:0]            rdata,
   input wire sosr_pkg::sosr_status_t status_in,
   input wire sosr_pkg::sosr_mode_t   mode_in,
   input wire logic                   output_terminal_one,
   input wire logic                   output_terminal_two,
   input wire logic                   output_terminal_three
);
   import sosr_pkg::*;
   logic [3:0] quiet;
   logic [2:0] pol_q;
   logic [2:0] term;
   assign term = {output_terminal_three, output_terminal_two, output_terminal_one};
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_b);
   // cycles since inputs or config last moved; outputs lag by up to five
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) quiet <= 4'h0;
      else if (!$stable(status_in) || !$stable(mode_in) || req.wr) quiet <= 4'h0;
      else if (quiet != 4'hf) quiet <= quiet + 4'h1;
   end
   // shadow of the polarity digits
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) pol_q <= RST_POLARITY[2:0];
      else if (req.wr && req.addr == ADDR_POLARITY) pol_q <= req.wdata[2:0];
   end
   // ==========================================================
   // register port
   rd_idle_a: assert property (!$past(req.rd) |-> rdata == 16'h0)
      else $error("rdata not zero outside a read");
   unmapped_rd_a: assert property ($past(req.rd) && $past(req.addr) > 4'h4 |-> rdata == 16'h0)
      else $error("unmapped read not zero");
   route_ab_a: assert property ($past(req.rd) && $past(req.addr) < 4'h2 |-> (rdata & 16'hcccc) == 16'h0)
      else $error("selector digit wider than two bits");
   route_c_a: assert property ($past(req.rd) && $past(req.addr) == ADDR_ROUTE_C |-> rdata[15:2] == 14'h0)
      else $error("route c reserved digits set");
   pol_mask_a: assert property ($past(req.rd) && $past(req.addr) == ADDR_POLARITY |-> rdata[15:3] == 13'h0)
      else $error("polarity reserved digit set");
   status_rd_a: assert property ($past(req.rd) && $past(req.addr) == ADDR_STATUS && quiet > 4'h6
      |-> rdata[15:3] == {11'h0, mode_in})
      else $error("status read does not show mode");
   // ==========================================================
   // terminals
   quiet_stable_a: assert property (quiet > 4'h5 |-> $stable(term))
      else $error("terminal moved with inputs settled");
   pol_flip_a: assert property (req.wr && req.addr == ADDR_POLARITY && quiet > 4'h6
      |-> ##3 (term ^ $past(term, 3)) == (pol_q ^ $past(pol_q, 3)))
      else $error("polarity write flipped wrong terminals");
endmodule

// ==== verif/sosr_wiring.sv ====
// Purpose: far-side wiring loaded by the three terminals
// Assumes: plain loads, no pull or sharing
// Notes:   gathers the terminals into one view
module sosr_wiring (
   input  wire logic       output_terminal_one,
   input  wire logic       output_terminal_two,
   input  wire logic       output_terminal_three,
   output logic      [2:0] seen
);
   // terminal three is the top bit
   assign seen = {output_terminal_three, output_terminal_two, output_terminal_one};
endmodule

// ==== verif/sosr_router_test.sv ====
// Purpose: self-checking bench for the output router
// Assumes: strobes one cycle, rdata one cycle later
// Notes:   terminals read after a settle margin
module sosr_router_test;
   timeunit 1ns;
   timeprecision 1ns;
   import sosr_pkg::*;
   logic         ref_clk;
   logic         rst_b;
   sosr_req_t    req;
   logic [15:0]  rdata;
   logic [15:0]  rv;
   sosr_status_t status_in;
   sosr_mode_t   mode_in;
   logic         t1;
   logic         t2;
   logic         t3;
   logic [2:0]   obs;
   int           failures;
   int           compares;
   sosr_router sosr_router_inst (.ref_clk(ref_clk), .rst_b(rst_b), .req(req), .rdata(rdata), .status_in(status_in),
      .mode_in(mode_in), .output_terminal_one(t1), .output_terminal_two(t2), .output_terminal_three(t3));
   sosr_wiring sosr_wiring_inst (.output_terminal_one(t1), .output_terminal_two(t2), .output_terminal_three(t3),
      .seen(obs));
   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end
   // ==========================================================
   // tasks
   task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
      compares++;
      if (g !== e) begin
         failures++;
         $display("[ERR] %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge ref_clk) req <= '{a, d, 1'b1, 1'b0};
      @(posedge ref_clk) req <= '0;
   endtask
   task automatic rd(input logic [3:0] a);
      @(posedge ref_clk) req <= '{a, 16'h0, 1'b0, 1'b1};
      @(posedge ref_clk) req <= '0;
      #1 rv = rdata;
   endtask
   // configure, set inputs, settle past the five-edge lag, compare
   task automatic run(input logic [15:0] a, b, c, p, input logic [9:0] s, input sosr_mode_t m,
      input logic [2:0] e);
      wr(ADDR_ROUTE_A, a);
      wr(ADDR_ROUTE_B, b);
      wr(ADDR_ROUTE_C, c);
      wr(ADDR_POLARITY, p);
      @(posedge ref_clk) status_in <= s;
      mode_in <= m;
      repeat (6) @(posedge ref_clk);
      #1 chk("terminals", {13'h0, e}, {13'h0, obs});
   endtask
   task automatic t_regs;
      logic [15:0] exp [5] = '{RST_ROUTE_A, RST_ROUTE_B, RST_ROUTE_C, RST_POLARITY, 16'h0};
      for (int i = 0; i < 5; i++) begin
         rd(4'(i));
         chk("register", exp[i], rv);
      end
      wr(4'h9, 16'hffff);
      rd(4'h9);
      chk("unmapped", 16'h0, rv);
      wr(ADDR_ROUTE_C, 16'hffff);
      rd(ADDR_ROUTE_C);
      chk("route_c", 16'h0003, rv);
      wr(ADDR_POLARITY, 16'hffff);
      rd(ADDR_POLARITY);
      chk("polarity", 16'h0007, rv);
   endtask
   task automatic t_select;
      for (int s = 0; s < 4; s++) run(16'(s), '0, '0, '0, 10'h001, SOSR_MODE_POSITION, 3'(s ? 1 << (s - 1) : 0));
   endtask
   task automatic t_or;
      run(16'h0020, 16'h3002, '0, '0, 10'h010, SOSR_MODE_POSITION, 3'b010);
      run(16'h0020, 16'h3002, '0, '0, 10'h012, SOSR_MODE_POSITION, 3'b010);
      run(16'h0020, 16'h3002, '0, '0, 10'h080, SOSR_MODE_POSITION, 3'b100);
      run(16'h0020, 16'h3002, '0, '0, 10'h100, SOSR_MODE_POSITION, 3'b100);
      run(16'h1300, 16'h0320, '0, '0, 10'h028, SOSR_MODE_POSITION, 3'b011);
      run(16'h1300, 16'h0320, '0, '0, 10'h044, SOSR_MODE_POSITION, 3'b100);
   endtask
   task automatic t_pol;
      run('0, '0, '0, 16'h0005, 10'h000, SOSR_MODE_POSITION, 3'b101);
      run(16'h0001, '0, '0, 16'h0001, 10'h001, SOSR_MODE_POSITION, 3'b000);
      repeat (8) @(posedge ref_clk);
      wr(ADDR_POLARITY, 16'h0002);
      repeat (2) @(posedge ref_clk);
      #1 chk("terminals", 16'h0003, {13'h0, obs});
   endtask
   task automatic t_mode;
      run(16'h0031, '0, 16'h0002, '0, 10'h203, SOSR_MODE_SPEED, 3'b100);
      rd(ADDR_STATUS);
      chk("status", 16'h000c, rv);
      run(16'h0031, '0, 16'h0002, '0, 10'h203, SOSR_MODE_POSITION, 3'b111);
      run(16'h0031, '0, 16'h0002, '0, 10'h203, SOSR_MODE_TORQUE, 3'b000);
   endtask
   task automatic print_verdict;
      if (failures == 0 && compares > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   // ==========================================================
   // main sequence and hang guard
   initial begin
      req = '0;
      status_in = '0;
      mode_in = SOSR_MODE_POSITION;
      rst_b = 1'b0;
      failures = 0;
      compares = 0;
      repeat (5) @(posedge ref_clk);
      rst_b <= 1'b1;
      t_regs();
      t_select();
      t_or();
      t_pol();
      t_mode();
      print_verdict();
   end
   initial begin
      #50us;
      failures++;
      print_verdict();
   end
endmodule
bind sosr_router sosr_router_sva sosr_router_sva_inst (.ref_clk(ref_clk), .rst_b(rst_b), .req(req), .rdata(rdata),
   .status_in(status_in), .mode_in(mode_in), .output_terminal_one(output_terminal_one),
   .output_terminal_two(output_terminal_two), .output_terminal_three(output_terminal_three));
